/* File: sbx_pkg.sv */
// Constants and types shared by the store, bit and shift execution unit.
package sbx_pkg;

	// ****************************************************************
	// Register bus map and field positions
	// ****************************************************************
	localparam int APB_AW = 8;
	localparam logic [APB_AW-1:0] OFS_CMD = 8'h00;
	localparam logic [APB_AW-1:0] OFS_STAT = 8'h04;
	localparam logic [APB_AW-1:0] OFS_GPR = 8'h08;
	localparam logic [APB_AW-1:0] OFS_PTRY = 8'h0C;
	localparam logic [APB_AW-1:0] OFS_PTRZ = 8'h10;
	localparam logic [APB_AW-1:0] OFS_SP = 8'h14;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_FLG_LSB = 8;
	localparam int GPR_DATA_LSB = 0;
	localparam int GPR_IDX_LSB = 8;
	localparam int GPR_WE_BIT = 15;

	// ****************************************************************
	// Flag positions inside the cpu flag register
	// ****************************************************************
	localparam int FLG_C = 0;
	localparam int FLG_Z = 1;
	localparam int FLG_N = 2;
	localparam int FLG_V = 3;
	localparam int FLG_S = 4;
	localparam int FLG_H = 5;
	localparam int FLG_T = 6;
	localparam int FLG_I = 7;

	// ****************************************************************
	// Reset values, cycle counts and pointer modes
	// ****************************************************************
	localparam logic [7:0] RST_FLAGS = 8'h00;
	localparam logic [15:0] RST_PTR = 16'h0000;
	localparam logic [15:0] RST_SP = 16'h0000;
	localparam logic [1:0] CYC_ONE = 2'h1;
	localparam logic [1:0] CYC_TWO = 2'h2;
	localparam logic [1:0] CYC_THREE = 2'h3;
	localparam logic [1:0] PMODE_PLAIN = 2'h0;
	localparam logic [1:0] PMODE_POST = 2'h1;
	localparam logic [1:0] PMODE_PRE = 2'h2;
	localparam int IO_AW = 6;
	localparam int PM_AW = 15;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef enum logic [4:0] {
		OP_NOP = 5'h00,
		OP_MEM_WRITE_VIA_POINTER = 5'h01,
		OP_MEM_WRITE_PTR_OFFSET = 5'h02,
		OP_MEM_WRITE_DIRECT = 5'h03,
		OP_PUSH = 5'h04,
		OP_POP = 5'h05,
		OP_PROGRAM_MEMORY_READ = 5'h06,
		OP_IN = 5'h07,
		OP_OUT = 5'h08,
		OP_SET_IO_BIT = 5'h09,
		OP_CLEAR_IO_BIT = 5'h0A,
		OP_LOGICAL_SHIFT_LEFT = 5'h0B,
		OP_LOGICAL_SHIFT_RIGHT = 5'h0C,
		OP_CARRY_ROTATE_LEFT = 5'h0D,
		OP_CARRY_ROTATE_RIGHT = 5'h0E,
		OP_ARITH_SHIFT_RIGHT = 5'h0F,
		OP_SWAP = 5'h10,
		OP_BIT_TO_TRANSFER_FLAG = 5'h11,
		OP_TRANSFER_FLAG_TO_BIT = 5'h12,
		OP_BSET = 5'h13,
		OP_BCLR = 5'h14
	} sbx_op_e;

	typedef enum logic {
		S_IDLE = 1'b0,
		S_EXEC = 1'b1
	} sbx_state_e;

	typedef struct packed {
		logic [15:0] imm;
		logic [1:0] ptr_mode;
		logic ptr_z;
		logic [2:0] bit_sel;
		logic [4:0] reg_idx;
		sbx_op_e op;
	} sbx_cmd_s;

	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] wdata;
		logic we;
		logic re;
	} sbx_dm_req_s;

	typedef struct packed {
		logic [IO_AW-1:0] addr;
		logic [7:0] wdata;
		logic we;
		logic re;
	} sbx_io_req_s;

	typedef struct packed {
		logic [PM_AW-1:0] addr;
		logic re;
	} sbx_pm_req_s;

endpackage

/* File: sbx_regfile.sv */
// General register file: one write port, one read port with registered data.
`timescale 1ns/1ps
module sbx_regfile #(
	parameter int DEPTH = 32,
	parameter int WIDTH = 8,
	parameter int AW = 5
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic we_i,
	input wire logic [AW-1:0] waddr_i,
	input wire logic [WIDTH-1:0] wdata_i,
	input wire logic [AW-1:0] raddr_i,
	output logic [WIDTH-1:0] rdata_o
);

	logic [WIDTH-1:0] mem [DEPTH];

	// The array itself is not reset so that it maps onto plain storage.
	always_ff @(posedge clk_i) begin
		if (we_i) begin
			mem[waddr_i] <= wdata_i;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_o <= '0;
		end else begin
			rdata_o <= mem[raddr_i];
		end
	end

endmodule

/* File: sbx_exec.sv */
// Execution unit for stores, stack, port, bit, shift and flag instructions.
//
// Local design decisions: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module sbx_exec
	import sbx_pkg::*;
(
	input wire logic CLOCK_I,
	input wire logic RESETN_I,
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [APB_AW-1:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	output logic [31:0] PRDATA_O,
	output logic PREADY_O,
	output logic PSLVERR_O,
	output sbx_dm_req_s DM_REQ_O,
	input wire logic [7:0] DM_RDATA_I,
	output sbx_io_req_s IO_REQ_O,
	input wire logic [7:0] IO_RDATA_I,
	output sbx_pm_req_s PM_REQ_O,
	input wire logic [15:0] PM_RDATA_I,
	output logic BUSY_O
);

	// ****************************************************************
	// Declarations
	// ****************************************************************
	sbx_state_e state, next_state;
	sbx_cmd_s cmd;
	sbx_cmd_s wcmd;
	sbx_dm_req_s dm_q, next_dm;
	sbx_pm_req_s pm_q;
	logic [1:0] cnt;
	logic [15:0] ptr_y, ptr_z, sp;
	logic [7:0] flags, next_flags;
	logic [4:0] gpr_sel;
	logic [7:0] opv;
	logic [7:0] io_mod;
	logic [7:0] sh_res;
	logic sh_c;
	logic [7:0] res1;
	logic rf_we;
	logic [4:0] rf_waddr;
	logic [7:0] rf_wdata;
	logic [31:0] rd_mux;
	logic [31:0] prdata;
	logic wait_q;

	function automatic logic [1:0] op_cycles(input sbx_op_e op);
		case (op)
			OP_MEM_WRITE_VIA_POINTER, OP_MEM_WRITE_PTR_OFFSET, OP_MEM_WRITE_DIRECT, OP_PUSH,
			OP_POP, OP_SET_IO_BIT, OP_CLEAR_IO_BIT: op_cycles = CYC_TWO;
			OP_PROGRAM_MEMORY_READ: op_cycles = CYC_THREE;
			default: op_cycles = CYC_ONE;
		endcase
	endfunction

	// ****************************************************************
	// Register bus decode
	// ****************************************************************
	// Every access gets one wait state so that a register file read can
	// settle before the data is captured.
	assign wcmd = sbx_cmd_s'(PWDATA_I);
	wire acc = PSEL_I & PENABLE_I;
	wire busy = (state == S_EXEC);
	wire hit_cmd = (PADDR_I == OFS_CMD);
	wire hit_stat = (PADDR_I == OFS_STAT);
	wire hit_gpr = (PADDR_I == OFS_GPR);
	wire hit_py = (PADDR_I == OFS_PTRY);
	wire hit_pz = (PADDR_I == OFS_PTRZ);
	wire hit_sp = (PADDR_I == OFS_SP);
	wire addr_ok = hit_cmd | hit_stat | hit_gpr | hit_py | hit_pz | hit_sp;
	wire wr_ok = acc & wait_q & PWRITE_I & addr_ok & ~busy;
	wire start = wr_ok & hit_cmd;
	assign PREADY_O = wait_q;
	assign PSLVERR_O = acc & wait_q & (~addr_ok | (PWRITE_I & busy));
	assign PRDATA_O = prdata;
	assign BUSY_O = busy;

	always_comb begin
		rd_mux = '0;
		if (hit_cmd) begin
			rd_mux = cmd;
		end else if (hit_stat) begin
			rd_mux[STAT_BUSY_BIT] = busy;
			rd_mux[STAT_FLG_LSB +: 8] = flags;
		end else if (hit_gpr) begin
			rd_mux[GPR_IDX_LSB +: 5] = gpr_sel;
			rd_mux[GPR_DATA_LSB +: 8] = opv;
		end else if (hit_py) begin
			rd_mux[15:0] = ptr_y;
		end else if (hit_pz) begin
			rd_mux[15:0] = ptr_z;
		end else if (hit_sp) begin
			rd_mux[15:0] = sp;
		end
	end

	always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			wait_q <= 1'b0;
			prdata <= '0;
		end else begin
			wait_q <= acc & ~wait_q;
			if (acc & ~wait_q) begin
				prdata <= rd_mux;
			end
		end
	end

	// ****************************************************************
	// Sequencer
	// ****************************************************************
	wire c1 = busy & (cnt == CYC_ONE);
	wire c2 = busy & (cnt == CYC_TWO);
	wire last = busy & (cnt == op_cycles(cmd.op));
	wire is_rmw = (cmd.op == OP_SET_IO_BIT) | (cmd.op == OP_CLEAR_IO_BIT);

	always_comb begin
		next_state = state;
		case (state)
			S_IDLE: if (start) next_state = S_EXEC;
			S_EXEC: if (last) next_state = S_IDLE;
			default: next_state = S_IDLE;
		endcase
	end

	always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			state <= S_IDLE;
			cnt <= CYC_ONE;
			cmd <= '0;
		end else begin
			state <= next_state;
			if (start) begin
				cnt <= CYC_ONE;
				cmd <= wcmd;
			end else if (busy & ~last) begin
				cnt <= cnt + 2'h1;
			end
		end
	end

	// ****************************************************************
	// Shifter and single-cycle results
	// ****************************************************************
	always_comb begin
		case (cmd.op)
			OP_LOGICAL_SHIFT_LEFT: {sh_c, sh_res} = {opv, 1'b0};
			OP_LOGICAL_SHIFT_RIGHT: {sh_res, sh_c} = {1'b0, opv};
			OP_CARRY_ROTATE_LEFT: {sh_c, sh_res} = {opv, flags[FLG_C]};
			OP_CARRY_ROTATE_RIGHT: {sh_res, sh_c} = {flags[FLG_C], opv};
			OP_ARITH_SHIFT_RIGHT: {sh_res, sh_c} = {opv[7], opv};
			default: {sh_res, sh_c} = {opv, flags[FLG_C]};
		endcase
	end

	always_comb begin
		res1 = sh_res;
		case (cmd.op)
			OP_SWAP: res1 = {opv[3:0], opv[7:4]};
			OP_TRANSFER_FLAG_TO_BIT: begin
				res1 = opv;
				res1[cmd.bit_sel] = flags[FLG_T];
			end
			OP_IN: res1 = IO_RDATA_I;
			default: res1 = sh_res;
		endcase
	end

	// ****************************************************************
	// Flags
	// ****************************************************************
	// Store, stack, port and program memory operations fall to the
	// default branch, so they never disturb the flags.
	always_comb begin
		next_flags = flags;
		if (wr_ok & hit_stat) begin
			next_flags = PWDATA_I[STAT_FLG_LSB +: 8];
		end else if (last) begin
			case (cmd.op)
				OP_LOGICAL_SHIFT_LEFT, OP_LOGICAL_SHIFT_RIGHT, OP_CARRY_ROTATE_LEFT,
				OP_CARRY_ROTATE_RIGHT, OP_ARITH_SHIFT_RIGHT: begin
					next_flags[FLG_C] = sh_c;
					next_flags[FLG_Z] = (sh_res == 8'h00);
					next_flags[FLG_N] = sh_res[7];
					next_flags[FLG_V] = sh_res[7] ^ sh_c;
				end
				OP_BIT_TO_TRANSFER_FLAG: next_flags[FLG_T] = opv[cmd.bit_sel];
				OP_BSET: next_flags[cmd.bit_sel] = 1'b1;
				OP_BCLR: next_flags[cmd.bit_sel] = 1'b0;
				default: next_flags = flags;
			endcase
		end
	end

	// ****************************************************************
	// General register file
	// ****************************************************************
	always_comb begin
		rf_we = 1'b0;
		rf_waddr = cmd.reg_idx;
		rf_wdata = res1;
		if (wr_ok & hit_gpr & PWDATA_I[GPR_WE_BIT]) begin
			rf_we = 1'b1;
			rf_waddr = PWDATA_I[GPR_IDX_LSB +: 5];
			rf_wdata = PWDATA_I[GPR_DATA_LSB +: 8];
		end else if (last) begin
			case (cmd.op)
				OP_LOGICAL_SHIFT_LEFT, OP_LOGICAL_SHIFT_RIGHT, OP_CARRY_ROTATE_LEFT,
				OP_CARRY_ROTATE_RIGHT, OP_ARITH_SHIFT_RIGHT: rf_we = 1'b1;
				OP_SWAP, OP_TRANSFER_FLAG_TO_BIT, OP_IN: rf_we = 1'b1;
				OP_POP: begin
					rf_we = 1'b1;
					rf_wdata = DM_RDATA_I;
				end
				OP_PROGRAM_MEMORY_READ: begin
					rf_we = 1'b1;
					rf_waddr = 5'h00;
					rf_wdata = ptr_z[0] ? PM_RDATA_I[15:8] : PM_RDATA_I[7:0];
				end
				default: rf_we = 1'b0;
			endcase
		end
	end

	// The operand is fetched at the very edge that takes the command, so
	// the first execution cycle already has it.
	wire [4:0] rf_raddr = start ? wcmd.reg_idx : (busy ? cmd.reg_idx : gpr_sel);

	sbx_regfile #(
		.DEPTH(32),
		.WIDTH(8),
		.AW(5)
	) u_regfile (
		.clk_i(CLOCK_I),
		.rst_n_i(RESETN_I),
		.we_i(rf_we),
		.waddr_i(rf_waddr),
		.wdata_i(rf_wdata),
		.raddr_i(rf_raddr),
		.rdata_o(opv)
	);

	// ****************************************************************
	// Data memory and stack
	// ****************************************************************
	wire [15:0] ptr_v = cmd.ptr_z ? ptr_z : ptr_y;
	wire [15:0] ptr_dec = ptr_v - 16'h0001;
	wire [15:0] ptr_new = (cmd.ptr_mode == PMODE_POST) ? ptr_v + 16'h0001 : ptr_dec;
	wire [15:0] disp_addr = ptr_v + {10'h000, cmd.imm[5:0]};
	wire ptr_step = c1 & (cmd.op == OP_MEM_WRITE_VIA_POINTER) &
		((cmd.ptr_mode == PMODE_POST) | (cmd.ptr_mode == PMODE_PRE));

	always_comb begin
		next_dm = '0;
		if (c1) begin
			next_dm.wdata = opv;
			case (cmd.op)
				OP_MEM_WRITE_VIA_POINTER: begin
					next_dm.addr = (cmd.ptr_mode == PMODE_PRE) ? ptr_dec : ptr_v;
					next_dm.we = 1'b1;
				end
				OP_MEM_WRITE_PTR_OFFSET: begin
					next_dm.addr = disp_addr;
					next_dm.we = 1'b1;
				end
				OP_MEM_WRITE_DIRECT: begin
					next_dm.addr = cmd.imm;
					next_dm.we = 1'b1;
				end
				OP_PUSH: begin
					next_dm.addr = sp;
					next_dm.we = 1'b1;
				end
				OP_POP: begin
					next_dm.addr = sp + 16'h0001;
					next_dm.re = 1'b1;
				end
				default: next_dm.we = 1'b0;
			endcase
		end
	end

	assign DM_REQ_O = dm_q;

	always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			dm_q <= '0;
			ptr_y <= RST_PTR;
			ptr_z <= RST_PTR;
			sp <= RST_SP;
		end else begin
			dm_q <= next_dm;
			if (ptr_step & ~cmd.ptr_z) begin
				ptr_y <= ptr_new;
			end else if (wr_ok & hit_py) begin
				ptr_y <= PWDATA_I[15:0];
			end
			if (ptr_step & cmd.ptr_z) begin
				ptr_z <= ptr_new;
			end else if (wr_ok & hit_pz) begin
				ptr_z <= PWDATA_I[15:0];
			end
			if (c1 & (cmd.op == OP_PUSH)) begin
				sp <= sp - 16'h0001;
			end else if (c1 & (cmd.op == OP_POP)) begin
				sp <= sp + 16'h0001;
			end else if (wr_ok & hit_sp) begin
				sp <= PWDATA_I[15:0];
			end
		end
	end

	// ****************************************************************
	// I/O space and program memory
	// ****************************************************************
	// Bit set and clear are a read-modify-write, which is why they take a
	// second cycle where a plain port write needs only one.
	wire [7:0] bit_mask = 8'h01 << cmd.bit_sel;
	wire io_re = c1 & ((cmd.op == OP_IN) | is_rmw);
	wire io_we = (c1 & (cmd.op == OP_OUT)) | (c2 & is_rmw);
	wire [7:0] io_wdata = (cmd.op == OP_OUT) ? opv : io_mod;

	assign IO_REQ_O = '{addr: cmd.imm[IO_AW-1:0], wdata: io_wdata, we: io_we, re: io_re};
	assign PM_REQ_O = pm_q;

	always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			io_mod <= 8'h00;
			pm_q <= '0;
		end else begin
			if (c1 & (cmd.op == OP_SET_IO_BIT)) begin
				io_mod <= IO_RDATA_I | bit_mask;
			end else if (c1 & (cmd.op == OP_CLEAR_IO_BIT)) begin
				io_mod <= IO_RDATA_I & ~bit_mask;
			end
			pm_q.addr <= ptr_z[15:1];
			pm_q.re <= c1 & (cmd.op == OP_PROGRAM_MEMORY_READ);
		end
	end

	// ****************************************************************
	// Flag and selector storage
	// ****************************************************************
	always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			flags <= RST_FLAGS;
			gpr_sel <= 5'h00;
		end else begin
			flags <= next_flags;
			if (wr_ok & hit_gpr) begin
				gpr_sel <= PWDATA_I[GPR_IDX_LSB +: 5];
			end
		end
	end

endmodule

/* File: sbx_mem_model.sv */
// Behavioural data memory, I/O space and program memory facing the execution unit.
`timescale 1ns/1ps
module sbx_mem_model
	import sbx_pkg::*;
(
	input wire logic clk_i,
	input wire sbx_dm_req_s dm_req_i,
	output logic [7:0] dm_rdata_o,
	input wire sbx_io_req_s io_req_i,
	output logic [7:0] io_rdata_o,
	input wire sbx_pm_req_s pm_req_i,
	output logic [15:0] pm_rdata_o
);
	// ****************************************************************
	// Storage and read paths
	// ****************************************************************
	logic [7:0] dm [256];
	logic [7:0] io [64];
	logic [7:0] junk = 8'h5A;
	logic [7:0] pw;
	// Idle read lines carry a moving pattern, so a read outside its cycle is never lucky.
	assign dm_rdata_o = dm_req_i.re ? dm[dm_req_i.addr[7:0]] : junk;
	assign io_rdata_o = io_req_i.re ? io[io_req_i.addr] : ~junk;
	assign pw = pm_req_i.addr[7:0];
	always @(posedge clk_i) begin
		junk <= junk + 8'h3B;
		if (dm_req_i.we) begin
			dm[dm_req_i.addr[7:0]] <= dm_req_i.wdata;
		end
		if (io_req_i.we) begin
			io[io_req_i.addr] <= io_req_i.wdata;
		end
		// A program word is valid only in the cycle after its request.
		pm_rdata_o <= pm_req_i.re ? {pw ^ 8'h5A, pw} : {junk, ~junk};
	end
endmodule

/* File: sbx_exec_chk.sv */
// Port assertions for the execution unit.
`timescale 1ns/1ps
module sbx_exec_chk
	import sbx_pkg::*;
(
	input wire logic CLOCK_I,
	input wire logic RESETN_I,
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [APB_AW-1:0] PADDR_I,
	input wire logic [31:0] PRDATA_O,
	input wire logic PREADY_O,
	input wire logic PSLVERR_O,
	input wire sbx_dm_req_s DM_REQ_O,
	input wire sbx_io_req_s IO_REQ_O,
	input wire sbx_pm_req_s PM_REQ_O,
	input wire logic BUSY_O
);
	// ****************************************************************
	// Properties
	// ****************************************************************
	default clocking cb @(posedge CLOCK_I); endclocking
	default disable iff (!RESETN_I);
	logic mapped;
	assign mapped = PADDR_I inside {OFS_CMD, OFS_STAT, OFS_GPR, OFS_PTRY, OFS_PTRZ, OFS_SP};
	a_ready_wait: assert property ($rose(PSEL_I && PENABLE_I) |-> !PREADY_O ##1 PREADY_O)
		else $error("ready not after one wait state");
	a_unmapped_err: assert property (PREADY_O && !mapped && !PWRITE_I |->
		PSLVERR_O && PRDATA_O == 32'h0000_0000) else $error("unmapped read not refused");
	a_busy_refuse: assert property (PREADY_O && PWRITE_I && BUSY_O |-> PSLVERR_O)
		else $error("write while busy not refused");
	a_busy_span: assert property ($rose(BUSY_O) |-> ##[1:3] !BUSY_O)
		else $error("busy too long");
	a_store_slot: assert property (DM_REQ_O.we |-> BUSY_O && $past(BUSY_O) ##1 !BUSY_O)
		else $error("store write not in second cycle");
	a_pop_slot: assert property (DM_REQ_O.re |-> $past(BUSY_O) ##1 !BUSY_O)
		else $error("pop read not in second cycle");
	a_pm_slot: assert property (PM_REQ_O.re |-> $past(BUSY_O) ##1 BUSY_O ##1 !BUSY_O)
		else $error("program read not in second of three cycles");
	a_io_read: assert property (IO_REQ_O.re |-> $rose(BUSY_O) ##1 IO_REQ_O.we == BUSY_O)
		else $error("port read sequence wrong");
	a_io_write: assert property (IO_REQ_O.we |-> BUSY_O ##1 !BUSY_O)
		else $error("port write not in last cycle");
	a_idle_quiet: assert property (!BUSY_O |->
		!(DM_REQ_O.we || DM_REQ_O.re || PM_REQ_O.re || IO_REQ_O.we))
		else $error("request while idle");
endmodule
bind sbx_exec sbx_exec_chk chk (.CLOCK_I(CLOCK_I), .RESETN_I(RESETN_I), .PSEL_I(PSEL_I),
	.PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PRDATA_O(PRDATA_O),
	.PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .DM_REQ_O(DM_REQ_O), .IO_REQ_O(IO_REQ_O),
	.PM_REQ_O(PM_REQ_O), .BUSY_O(BUSY_O));

/* File: tb_sbx_exec.sv */
// Self-checking bench for the execution unit and its memory model.
`timescale 1ns/1ps
module tb_sbx_exec
	import sbx_pkg::*;
;
	// ****************************************************************
	// Signals, model and tasks
	// ****************************************************************
	logic CLOCK_I = 1'b0;
	logic RESETN_I = 1'b0;
	logic PSEL_I = 1'b0;
	logic PENABLE_I = 1'b0;
	logic PWRITE_I = 1'b0;
	logic [7:0] PADDR_I = 8'h00;
	logic [31:0] PWDATA_I = 32'h0000_0000;
	logic [31:0] PRDATA_O;
	logic PREADY_O, PSLVERR_O, BUSY_O, er;
	logic [31:0] rd;
	sbx_dm_req_s DM_REQ_O;
	sbx_io_req_s IO_REQ_O;
	sbx_pm_req_s PM_REQ_O;
	logic [7:0] dm_rdata, io_rdata;
	logic [15:0] pm_rdata;
	int fail_count = 0;
	int total_checks = 0;
	int cyc = 0;
	sbx_op_e sop [7] = '{OP_LOGICAL_SHIFT_LEFT, OP_LOGICAL_SHIFT_RIGHT, OP_CARRY_ROTATE_LEFT,
		OP_CARRY_ROTATE_RIGHT, OP_ARITH_SHIFT_RIGHT, OP_LOGICAL_SHIFT_LEFT, OP_SWAP};
	logic [23:0] tv [7] = '{24'h81_02E9, 24'h81_40E9, 24'h81_03E9, 24'h81_C0E5, 24'h81_C0E5,
		24'h80_00EB, 24'h81_18E1};
	sbx_exec uut (.CLOCK_I(CLOCK_I), .RESETN_I(RESETN_I), .PSEL_I(PSEL_I),
		.PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I),
		.PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .DM_REQ_O(DM_REQ_O),
		.DM_RDATA_I(dm_rdata), .IO_REQ_O(IO_REQ_O), .IO_RDATA_I(io_rdata), .PM_REQ_O(PM_REQ_O),
		.PM_RDATA_I(pm_rdata), .BUSY_O(BUSY_O));
	sbx_mem_model mdl (.clk_i(CLOCK_I), .dm_req_i(DM_REQ_O), .dm_rdata_o(dm_rdata),
		.io_req_i(IO_REQ_O), .io_rdata_o(io_rdata), .pm_req_i(PM_REQ_O), .pm_rdata_o(pm_rdata));
	always #5 CLOCK_I = ~CLOCK_I;
	// The ceiling sits far above the few hundred cycles the tests need.
	always @(posedge CLOCK_I) begin
		cyc++;
		if (cyc == 5000) begin
			fail_count++;
			close_out();
		end
	end
	task automatic close_out;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected %s: expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Called just after an edge; leaves the select up so a next transfer may follow at once.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		PSEL_I <= 1'b1;
		PENABLE_I <= 1'b0;
		PWRITE_I <= w;
		PADDR_I <= a;
		PWDATA_I <= d;
		@(posedge CLOCK_I);
		PENABLE_I <= 1'b1;
		@(posedge CLOCK_I);
		while (PREADY_O !== 1'b1) @(posedge CLOCK_I);
		rd = PRDATA_O;
		er = PSLVERR_O;
	endtask
	task automatic cp(input string nm, input logic [7:0] a, input logic [31:0] v);
		apb(1'b0, a, 32'h0000_0000);
		chk(nm, rd, v);
	endtask
	task automatic setr(input logic [4:0] i, input logic [7:0] v);
		apb(1'b1, OFS_GPR, {16'h0000, 3'h4, i, v});
	endtask
	task automatic chr(input logic [4:0] i, input logic [7:0] v);
		apb(1'b1, OFS_GPR, {19'h0_0000, i, 8'h00});
		apb(1'b0, OFS_GPR, 32'h0000_0000);
		chk("gpr", rd[7:0], v);
	endtask
	task automatic chf(input logic [7:0] v);
		apb(1'b0, OFS_STAT, 32'h0000_0000);
		chk("flags", rd[15:8], v);
	endtask
	task automatic ex(input sbx_op_e op, input logic [4:0] r, input logic [2:0] b,
		input logic z, input logic [1:0] m, input logic [15:0] imm, input int n);
		int c;
		c = 0;
		apb(1'b1, OFS_CMD, {imm, m, z, b, r, op});
		PSEL_I <= 1'b0;
		PENABLE_I <= 1'b0;
		@(posedge CLOCK_I);
		while (BUSY_O === 1'b1 && c < 8) begin
			c++;
			@(posedge CLOCK_I);
		end
		chk("cycles", c, n);
	endtask
	// ****************************************************************
	// Test sequence
	// ****************************************************************
	initial begin
		repeat (8) @(posedge CLOCK_I);
		RESETN_I <= 1'b1;
		cp("stat", OFS_STAT, 32'h0000_0000);
		cp("unmapped", 8'h18, 32'h0000_0000);
		chk("slverr", er, 1'b1);
		apb(1'b1, OFS_STAT, 32'h0000_A500);
		setr(5'h03, 8'h3C);
		apb(1'b1, OFS_PTRY, 32'h0000_0040);
		ex(OP_MEM_WRITE_VIA_POINTER, 5'h03, 3'h0, 1'b0, PMODE_POST, 16'h0000, 2);
		chk("dm40", mdl.dm[8'h40], 8'h3C);
		cp("y_inc", OFS_PTRY, 32'h0000_0041);
		apb(1'b1, OFS_PTRZ, 32'h0000_0050);
		ex(OP_MEM_WRITE_VIA_POINTER, 5'h03, 3'h0, 1'b1, PMODE_PRE, 16'h0000, 2);
		chk("dm4f", mdl.dm[8'h4F], 8'h3C);
		cp("z_dec", OFS_PTRZ, 32'h0000_004F);
		ex(OP_MEM_WRITE_PTR_OFFSET, 5'h03, 3'h0, 1'b0, PMODE_PLAIN, 16'h0005, 2);
		chk("dm46", mdl.dm[8'h46], 8'h3C);
		cp("y_kept", OFS_PTRY, 32'h0000_0041);
		ex(OP_MEM_WRITE_DIRECT, 5'h03, 3'h0, 1'b0, PMODE_PLAIN, 16'h0080, 2);
		chk("dm80", mdl.dm[8'h80], 8'h3C);
		apb(1'b1, OFS_SP, 32'h0000_00F0);
		ex(OP_PUSH, 5'h03, 3'h0, 1'b0, PMODE_PLAIN, 16'h0000, 2);
		chk("dmf0", mdl.dm[8'hF0], 8'h3C);
		ex(OP_POP, 5'h04, 3'h0, 1'b0, PMODE_PLAIN, 16'h0000, 2);
		chr(5'h04, 8'h3C);
		cp("sp", OFS_SP, 32'h0000_00F0);
		chf(8'hA5);
		$display("test stores done");
		ex(OP_OUT, 5'h03, 3'h0, 1'b0, PMODE_PLAIN, 16'h0010, 1);
		ex(OP_SET_IO_BIT, 5'h00, 3'h0, 1'b0, PMODE_PLAIN, 16'h0010, 2);
		chk("io_set", mdl.io[6'h10], 8'h3D);
		ex(OP_CLEAR_IO_BIT, 5'h00, 3'h2, 1'b0, PMODE_PLAIN, 16'h0010, 2);
		ex(OP_IN, 5'h06, 3'h0, 1'b0, PMODE_PLAIN, 16'h0010, 1);
		chr(5'h06, 8'h39);
		chf(8'hA5);
		apb(1'b1, OFS_PTRZ, 32'h0000_0007);
		ex(OP_PROGRAM_MEMORY_READ, 5'h00, 3'h0, 1'b0, PMODE_PLAIN, 16'h0000, 3);
		apb(1'b1, OFS_CMD, {27'h000_0000, OP_PROGRAM_MEMORY_READ});
		setr(5'h00, 8'hFF);
		chk("busy_err", er, 1'b1);
		chr(5'h00, 8'h59);
		chf(8'hA5);
		$display("test ports done");
		for (int i = 0; i < 7; i++) begin
			apb(1'b1, OFS_STAT, 32'h0000_E100);
			setr(5'h07, tv[i][23:16]);
			ex(sop[i], 5'h07, 3'h0, 1'b0, PMODE_PLAIN, 16'h0000, 1);
			chr(5'h07, tv[i][15:8]);
			chf(tv[i][7:0]);
		end
		apb(1'b1, OFS_STAT, 32'h0000_0000);
		ex(OP_BIT_TO_TRANSFER_FLAG, 5'h07, 3'h4, 1'b0, PMODE_PLAIN, 16'h0000, 1);
		chf(8'h40);
		setr(5'h08, 8'h00);
		ex(OP_TRANSFER_FLAG_TO_BIT, 5'h08, 3'h2, 1'b0, PMODE_PLAIN, 16'h0000, 1);
		chr(5'h08, 8'h04);
		chf(8'h40);
		for (int s = 0; s < 8; s++) begin
			apb(1'b1, OFS_STAT, 32'h0000_0000);
			ex(OP_BSET, 5'h00, 3'(s), 1'b0, PMODE_PLAIN, 16'h0000, 1);
			chf(8'h01 << s);
			apb(1'b1, OFS_STAT, 32'h0000_FF00);
			ex(OP_BCLR, 5'h00, 3'(s), 1'b0, PMODE_PLAIN, 16'h0000, 1);
			chf(~(8'h01 << s));
		end
		$display("test shifts and flags done");
		PSEL_I <= 1'b0;
		PENABLE_I <= 1'b0;
		@(posedge CLOCK_I);
		close_out();
	end
endmodule
